// [verilog/incn_cfg.svh]
`ifndef INCN_CFG_SVH
`define INCN_CFG_SVH
// Functional notes
// R1: Holding the null switch toward the first channel nulls it with a tone and a blinking green lamp.
// R2: A null lasts about 7.5 seconds from start to completion.
// R3: On success the tone stops and the lamp turns steady green.
// R4: On failure the lamp shows red, and a new switch request retries the null.
// R5: The second switch direction runs the same sequence on the second channel's lamp.
// R6: Null requests have no effect unless the unit is in two-wire mode.
// R7: At power-up both null lamps go green, then red, then off.
// R8: The power-up test cycles only the null lamps.
// R9: Any out-of-range supply level blinks the null lamps red while operation continues; the power-up test and a running null's green blink take precedence.
// R10: The configuring party sets system type, then two- or four-wire mode, then power or attachment.
// R11: In two-wire mode call indications are translated between the system types at the two ends.
// R12: When optical link strength falls below threshold the signal is cut entirely.
// R13: While a null runs, further null requests are ignored until success or failure.

// ============================================================
// Timing
`define INCN_CLK_HZ        100000000
`define INCN_NULL_TIME_MS  7500
`define INCN_LAMP_TIME_MS  500
`define INCN_BLINK_TIME_MS 250
`define INCN_NULL_CYC  ((`INCN_CLK_HZ / 1000) * `INCN_NULL_TIME_MS)
`define INCN_LAMP_CYC  ((`INCN_CLK_HZ / 1000) * `INCN_LAMP_TIME_MS)
`define INCN_BLINK_CYC ((`INCN_CLK_HZ / 1000) * `INCN_BLINK_TIME_MS)

// ============================================================
// Lamp colour codes {red, green}
`define INCN_LAMP_OFF   2'h0
`define INCN_LAMP_GREEN 2'h1
`define INCN_LAMP_RED   2'h2
`define INCN_CH_FIRST   1'h0
`define INCN_CH_SECOND  1'h1
`endif

// [verilog/incn_pkg.sv]
package incn_pkg;
  typedef enum logic [2:0] {
    INCN_TEST_GREEN = 3'h0,
    INCN_TEST_RED   = 3'h1,
    INCN_IDLE       = 3'h2,
    INCN_NULLING    = 3'h3
  } incn_state_e;
  typedef logic [1:0] incn_lamp_t;
endpackage

// [verilog/incn_sync.sv]
module incn_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  wire  [W-1:0] agree_w = ~(s2_r ^ s3_r);

  // ============================================================
  // Three stages, change accepted when stage two and three agree
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= (agree_w & s3_r) | (~agree_w & out_r);
    end
  end
  assign sync_o = out_r;
endmodule

// [verilog/incn_null_sequencer.sv]
`include "incn_cfg.svh"
module incn_null_sequencer #(
  parameter int NULL_CYC  = `INCN_NULL_CYC,
  parameter int LAMP_CYC  = `INCN_LAMP_CYC,
  parameter int BLINK_CYC = `INCN_BLINK_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       null_to_first_channel_i,
  input  wire logic       null_to_second_channel_i,
  input  wire logic       two_wire_mode_i,
  input  wire logic       system_type_a_i,
  input  wire logic       externally_powered_i,
  input  wire logic       frame_attached_i,
  input  wire logic       power_fault_i,
  input  wire logic       link_strength_ok_i,
  input  wire logic       null_done_i,
  input  wire logic       null_pass_i,
  input  wire logic       local_call_i,
  input  wire logic       remote_call_i,
  input  wire logic       remote_system_type_a_i,
  input  wire logic [1:0] other_lamps_i,
  output logic            null_start_o,
  output logic            null_channel_o,
  output logic            test_tone_o,
  output logic      [1:0] first_channel_lamp_o,
  output logic      [1:0] second_channel_lamp_o,
  output logic      [1:0] other_lamps_o,
  output logic            termination_on_o,
  output logic            panel_mode_o,
  output logic            call_to_local_o,
  output logic            call_to_remote_o,
  output logic            signal_pass_o
);
  initial begin
    if (NULL_CYC < 1) begin
      $error("incn_null_sequencer: null count must be at least one");
    end
    if (LAMP_CYC < 1) begin
      $error("incn_null_sequencer: lamp test count must be at least one");
    end
    if (BLINK_CYC < 1) begin
      $error("incn_null_sequencer: blink count must be at least one");
    end
  end

  localparam int CW = $clog2(NULL_CYC + LAMP_CYC + BLINK_CYC + 1);

  // ============================================================
  // Pin synchronisers
  logic [4:0] sy_w;
  incn_sync #(.W(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({null_to_first_channel_i, null_to_second_channel_i, two_wire_mode_i,
                 power_fault_i, link_strength_ok_i}),
    .sync_o    (sy_w)
  );
  wire req_first_w  = sy_w[4];
  wire req_second_w = sy_w[3];
  wire two_wire_w   = sy_w[2];
  wire fault_w      = sy_w[1];
  wire link_ok_w    = sy_w[0];

  // ============================================================
  // State
  incn_pkg::incn_state_e state_r, state_nxt;
  logic [CW-1:0]         tmr_r;
  logic [CW-1:0]         blink_cnt_r;
  logic                  blink_r;
  logic                  chan_r;
  incn_pkg::incn_lamp_t  res_first_r;
  incn_pkg::incn_lamp_t  res_second_r;
  logic                  start_r;

  wire idle_w      = (state_r == incn_pkg::INCN_IDLE);
  wire req_w       = two_wire_w & (req_first_w | req_second_w);          // [R6]
  wire start_w     = idle_w & req_w;                                      // [R13]
  wire start_ch_w  = req_first_w ? `INCN_CH_FIRST : `INCN_CH_SECOND;      // [R5]
  wire tmr_end_w   = (tmr_r == '0);
  wire null_end_w  = (state_r == incn_pkg::INCN_NULLING) & (null_done_i | tmr_end_w);
  wire pass_w      = null_done_i & null_pass_i;
  wire blink_end_w = (blink_cnt_r == '0);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      incn_pkg::INCN_TEST_GREEN: begin
        if (tmr_end_w) begin
          state_nxt = incn_pkg::INCN_TEST_RED;
        end
      end
      incn_pkg::INCN_TEST_RED: begin
        if (tmr_end_w) begin
          state_nxt = incn_pkg::INCN_IDLE;
        end
      end
      incn_pkg::INCN_IDLE: begin
        if (start_w) begin
          state_nxt = incn_pkg::INCN_NULLING;
        end
      end
      incn_pkg::INCN_NULLING: begin
        if (null_end_w) begin
          state_nxt = incn_pkg::INCN_IDLE;
        end
      end
      default:                   state_nxt = incn_pkg::INCN_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= incn_pkg::INCN_TEST_GREEN;                               // [R7]
      tmr_r   <= CW'(LAMP_CYC - 1);
    end else begin
      state_r <= state_nxt;
      if (start_w) begin
        tmr_r <= CW'(NULL_CYC - 1);                                       // [R2]
      end else if (state_r != state_nxt) begin
        tmr_r <= CW'(LAMP_CYC - 1);
      end else if (!tmr_end_w) begin
        tmr_r <= tmr_r - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_cnt_r <= CW'(BLINK_CYC - 1);
      blink_r     <= 1'b0;
    end else if (blink_end_w) begin
      blink_cnt_r <= CW'(BLINK_CYC - 1);
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r - CW'(1);
    end
  end

  // Result latches; a timeout without completion counts as failure
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_r       <= `INCN_CH_FIRST;
      start_r      <= 1'b0;
      res_first_r  <= `INCN_LAMP_OFF;
      res_second_r <= `INCN_LAMP_OFF;
    end else begin
      start_r <= start_w;
      if (start_w) begin
        chan_r <= start_ch_w;
      end
      if (null_end_w && chan_r == `INCN_CH_FIRST) begin
        res_first_r <= pass_w ? `INCN_LAMP_GREEN : `INCN_LAMP_RED;        // [R3] [R4]
      end
      if (null_end_w && chan_r == `INCN_CH_SECOND) begin
        res_second_r <= pass_w ? `INCN_LAMP_GREEN : `INCN_LAMP_RED;       // [R3] [R4]
      end
    end
  end

  // ============================================================
  // Lamp selection
  wire nulling_w = (state_r == incn_pkg::INCN_NULLING);
  wire [1:0] test_w    = (state_r == incn_pkg::INCN_TEST_GREEN) ? `INCN_LAMP_GREEN
                                                                : `INCN_LAMP_RED;
  wire testing_w = (state_r == incn_pkg::INCN_TEST_GREEN) |
                   (state_r == incn_pkg::INCN_TEST_RED);

  // Everything the choice depends on is an argument, so each call re-evaluates on any change
  function automatic incn_pkg::incn_lamp_t lamp_sel(input logic                 testing,
                                                    input logic                 busy,
                                                    input logic                 fault,
                                                    input logic                 blink,
                                                    input incn_pkg::incn_lamp_t test,
                                                    input incn_pkg::incn_lamp_t res);
    if (testing) begin
      lamp_sel = test;                                                    // [R7]
    end else if (busy) begin
      lamp_sel = blink ? `INCN_LAMP_GREEN : `INCN_LAMP_OFF;               // [R1] [R5]
    end else if (fault) begin
      lamp_sel = blink ? `INCN_LAMP_RED : `INCN_LAMP_OFF;                 // [R9]
    end else begin
      lamp_sel = res;
    end
  endfunction

  wire [1:0] lamp1_w = lamp_sel(testing_w, nulling_w & (chan_r == `INCN_CH_FIRST), fault_w,
                                blink_r, test_w, res_first_r);
  wire [1:0] lamp2_w = lamp_sel(testing_w, nulling_w & (chan_r == `INCN_CH_SECOND), fault_w,
                                blink_r, test_w, res_second_r);

  // Call translation: the far end's call is re-signalled in local convention
  wire call_in_w  = remote_call_i ^ (remote_system_type_a_i ^ system_type_a_i);
  wire call_out_w = local_call_i;

  // ============================================================
  // Output registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      null_start_o          <= 1'b0;
      null_channel_o        <= 1'b0;
      test_tone_o           <= 1'b0;
      first_channel_lamp_o  <= `INCN_LAMP_OFF;
      second_channel_lamp_o <= `INCN_LAMP_OFF;
      other_lamps_o         <= 2'h0;
      termination_on_o      <= 1'b0;
      panel_mode_o          <= 1'b0;
      call_to_local_o       <= 1'b0;
      call_to_remote_o      <= 1'b0;
      signal_pass_o         <= 1'b0;
    end else begin
      null_start_o          <= start_r;
      null_channel_o        <= chan_r;
      test_tone_o           <= nulling_w;                                 // [R1] [R3]
      first_channel_lamp_o  <= lamp1_w;
      second_channel_lamp_o <= lamp2_w;
      other_lamps_o         <= other_lamps_i;                             // [R8]
      termination_on_o      <= two_wire_w & ~externally_powered_i;
      panel_mode_o          <= ~two_wire_w & ~frame_attached_i;
      call_to_local_o       <= two_wire_w & link_ok_w & call_in_w;        // [R11]
      call_to_remote_o      <= two_wire_w & link_ok_w & call_out_w;       // [R11]
      signal_pass_o         <= link_ok_w;                                 // [R12]
    end
  end
endmodule

// [tb/incn_null_sequencer_properties.sv]
module incn_null_sequencer_chk #(
  parameter int NULL_CYC = 50
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       two_wire_mode_i,
  input wire logic       power_fault_i,
  input wire logic       link_strength_ok_i,
  input wire logic       null_done_i,
  input wire logic       null_pass_i,
  input wire logic [1:0] other_lamps_i,
  input wire logic       null_start_o,
  input wire logic       null_channel_o,
  input wire logic       test_tone_o,
  input wire logic [1:0] first_channel_lamp_o,
  input wire logic [1:0] second_channel_lamp_o,
  input wire logic [1:0] other_lamps_o,
  input wire logic       signal_pass_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ============================================================
  // Null run length
  int unsigned tone_cnt_r;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) tone_cnt_r <= 0;
    else tone_cnt_r <= test_tone_o ? tone_cnt_r + 1 : 0;
  end
  sequence s_end(ok, ch);
    test_tone_o && null_done_i && null_pass_i == ok && null_channel_o == ch && !power_fault_i;
  endsequence
  property p_res(ok, ch, lamp);
    s_end(ok, ch) |-> ##2 !test_tone_o && lamp == (ok ? 2'h1 : 2'h2);
  endproperty
  // ============================================================
  // Properties
  tone_start_a: assert property ($rose(test_tone_o) |-> null_start_o ##1 !null_start_o)
    else $error("tone rose without a single start pulse");
  tone_length_a: assert property (tone_cnt_r <= NULL_CYC + 2)
    else $error("null ran past its time limit");
  first_pass_a: assert property (p_res(1'h1, 1'h0, first_channel_lamp_o))
    else $error("first lamp not steady green after success");
  first_fail_a: assert property (p_res(1'h0, 1'h0, first_channel_lamp_o))
    else $error("first lamp not red after failure");
  second_pass_a: assert property (p_res(1'h1, 1'h1, second_channel_lamp_o))
    else $error("second lamp not steady green after success");
  four_wire_a: assert property ((!two_wire_mode_i) [*8] |-> !$rose(test_tone_o))
    else $error("null started in four-wire mode");
  other_lamp_a: assert property ($past(rst_b_i, 2) |-> other_lamps_o == $past(other_lamps_i))
    else $error("other lamps disturbed");
  fault_red_a: assert property (power_fault_i [*8] ##0 !test_tone_o
    |-> !first_channel_lamp_o[0] && !second_channel_lamp_o[0])
    else $error("lamp green during supply fault");
  link_cut_a: assert property ((!link_strength_ok_i) [*6] |-> !signal_pass_o)
    else $error("signal passed with weak link");
  busy_ignore_a: assert property (test_tone_o && $past(test_tone_o) |-> !null_start_o)
    else $error("new null started during a null");
endmodule

// [tb/incn_null_engine.sv]
module incn_null_engine (
  input  wire logic        sys_clk_i,
  input  wire logic        start_i,
  input  wire logic [15:0] dly_i,
  input  wire logic        pass_i,
  output logic             done_o,
  output logic             pass_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  initial begin
    done_o = 1'h0;
    pass_o = 1'h0;
  end
  // Result flag is only valid with the done pulse; otherwise it shows the inverse
  always @(posedge sys_clk_i) begin
    #1;
    done_o = (cnt == 0);
    pass_o = (cnt == 0) ? pass_i : !pass_i;
    cnt = start_i ? int'(dly_i) : (cnt >= 0 ? cnt - 1 : -1);
  end
endmodule

// [tb/tb_incn_null_sequencer.sv]
module tb_incn_null_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, two_wire_mode_i = 1'h1, power_fault_i = 1'h0;
  logic null_to_first_channel_i = 1'h0, null_to_second_channel_i = 1'h0;
  logic system_type_a_i = 1'h0, externally_powered_i = 1'h0, frame_attached_i = 1'h0;
  logic link_strength_ok_i = 1'h1, local_call_i = 1'h0, remote_call_i = 1'h0;
  logic remote_system_type_a_i = 1'h1, null_done_i, null_pass_i, null_start_o, null_channel_o;
  logic test_tone_o, termination_on_o, panel_mode_o, call_to_local_o, call_to_remote_o;
  logic [1:0] other_lamps_i = 2'h0, first_channel_lamp_o, second_channel_lamp_o, other_lamps_o;
  logic signal_pass_o, prev = 1'h0, dpass = 1'h1;
  logic [15:0] dly = 16'h14;
  logic [31:0] seed = 32'h2B99;
  logic [3:0] q[$], acc;
  logic [1:0] lamp_e[2] = '{2'h0, 2'h0};
  int n_fail = 0, comparisons = 0, cyc = 0, i;
  always #5 sys_clk_i = ~sys_clk_i;
  incn_null_sequencer #(.NULL_CYC(50), .LAMP_CYC(10), .BLINK_CYC(3)) incn_null_sequencer_i (.*);
  incn_null_engine incn_null_engine_i (.sys_clk_i, .start_i(null_start_o), .dly_i(dly),
    .pass_i(dpass), .done_o(null_done_i), .pass_o(null_pass_i));
  // ============================================================
  // Helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
    seed = lfsr(seed);
    {other_lamps_i, local_call_i, remote_call_i} = seed[3:0];
  endtask
  task automatic chk(logic [3:0] a, logic [3:0] e);
    comparisons++;
    if (a !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic wt(logic v);
    for (i = 0; i < 200 && test_tone_o !== v; i++) tick(1);
    chk(test_tone_o, v);
  endtask
  task automatic run_null(logic ch, logic ok, logic [15:0] d);
    dly = d;
    dpass = ok;
    if (ch) null_to_second_channel_i = 1'h1;
    else null_to_first_channel_i = 1'h1;
    wt(1'h1);
    chk(null_channel_o, ch);
    lamp_e[ch] = ok ? 2'h1 : 2'h2;
    q.push_back({lamp_e[0], lamp_e[1]});
    {null_to_first_channel_i, null_to_second_channel_i} = ch ? 2'h2 : 2'h1;
    acc = 4'h0;
    for (i = 0; i < 8; i++) begin
      tick(1);
      acc |= ch ? second_channel_lamp_o : first_channel_lamp_o;
    end
    {null_to_first_channel_i, null_to_second_channel_i} = 2'h0;
    chk(acc, 4'h1);
    wt(1'h0);
    tick(8);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ============================================================
  // Result monitor and run limit
  always @(posedge sys_clk_i) begin
    #2;
    if (prev && !test_tone_o) chk({first_channel_lamp_o, second_channel_lamp_o}, q.pop_front());
    prev = test_tone_o;
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ============================================================
  // Main sequence
  initial begin
    tick(6);
    rst_b_i = 1'h1;
    for (i = 0; i < 20 && first_channel_lamp_o !== 2'h1; i++) tick(1);
    tick(4);
    chk({first_channel_lamp_o, second_channel_lamp_o}, 4'h5);
    tick(10);
    chk({first_channel_lamp_o, second_channel_lamp_o}, 4'hA);
    tick(10);
    chk({first_channel_lamp_o, second_channel_lamp_o}, 4'h0);
    run_null(1'h0, 1'h0, 16'h14 + seed[3:0]);
    run_null(1'h0, 1'h1, 16'h14 + seed[3:0]);
    run_null(1'h1, 1'h1, 16'h14 + seed[3:0]);
    two_wire_mode_i = 1'h0;
    null_to_first_channel_i = 1'h1;
    tick(30);
    chk(test_tone_o, 1'h0);
    chk({termination_on_o, panel_mode_o}, 4'h1);
    frame_attached_i = 1'h1;
    tick(2);
    chk({termination_on_o, panel_mode_o}, 4'h0);
    frame_attached_i = 1'h0;
    null_to_first_channel_i = 1'h0;
    two_wire_mode_i = 1'h1;
    power_fault_i = 1'h1;
    tick(8);
    acc = 4'h0;
    for (i = 0; i < 8; i++) begin
      tick(1);
      acc |= {first_channel_lamp_o, second_channel_lamp_o};
    end
    chk(acc, 4'hA);
    power_fault_i = 1'h0;
    link_strength_ok_i = 1'h0;
    tick(8);
    chk({signal_pass_o, call_to_local_o, call_to_remote_o}, 4'h0);
    link_strength_ok_i = 1'h1;
    tick(8);
    chk(signal_pass_o, 1'h1);
    for (i = 0; i < 8; i++) begin
      system_type_a_i = seed[5];
      acc = {other_lamps_i, remote_call_i ^ remote_system_type_a_i ^ system_type_a_i,
             local_call_i};
      tick(1);
      chk({other_lamps_o, call_to_local_o, call_to_remote_o}, acc);
    end
    chk({termination_on_o, panel_mode_o}, 4'h2);
    externally_powered_i = 1'h1;
    tick(2);
    chk({termination_on_o, panel_mode_o}, 4'h0);
    run_null(1'h1, 1'h0, 16'hFFFF);
    tick(10);
    end_of_test();
  end
endmodule
bind incn_null_sequencer incn_null_sequencer_chk #(.NULL_CYC(NULL_CYC)) incn_null_sequencer_chk_i (.*);
